/* File: cell_port_pkg.sv */
// shared constants, state codes and helpers for both ends of the cell link
// assumes one core clock of 100 MHz on both ends and a single cell length
package cell_port_pkg;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 5;
	localparam int CELL_BYTES = 12;
	localparam int FIFO_DEPTH = 16;
	localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
	localparam int CNT_W = 5;
	localparam int CORE_CLK_PERIOD_NS = 10;
	localparam int LINK_CLK_PERIOD_NS = 80;
	localparam int LINK_HALF_CYCLES = LINK_CLK_PERIOD_NS / (2 * CORE_CLK_PERIOD_NS);
	localparam int LINK_DIV_W = $clog2(LINK_HALF_CYCLES);
	localparam int POLL_WAIT_FALLS = 2;

	typedef enum logic [0:0] {
		PORT_IDLE = 1'b0,
		PORT_BUSY = 1'b1
	} port_state_t;

	typedef enum logic [1:0] {
		MOVE_POLL = 2'b00,
		MOVE_CHECK = 2'b01,
		MOVE_XFER = 2'b11
	} move_state_t;

	function automatic logic last_byte(input logic [CNT_W-1:0] cnt);
		return cnt == CNT_W'(CELL_BYTES - 1);
	endfunction

	function automatic logic [CNT_W-1:0] wait_done(input logic [CNT_W-1:0] cnt);
		return (cnt == CNT_W'(POLL_WAIT_FALLS - 1)) ? '0 : cnt + 1'b1;
	endfunction
endpackage

/* File: cell_link_if.sv */
// pin bundle between the cell master and the cell slave
// the slave's cell-available flags are three-state; an undriven flag reads low here
interface cell_link_if import cell_port_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	logic tx_link_clock;
	logic [BYTE_W-1:0] tx_cell_byte_bus;
	logic tx_cell_ready_flag_o;
	logic tx_cell_ready_flag_oe;
	logic tx_cell_ready_flag;
	logic tx_enable_n;
	logic tx_start_of_cell;
	logic [ADDR_W-1:0] tx_slave_select_addr;
	logic rx_link_clock;
	logic rx_space_ready_flag_o;
	logic rx_space_ready_flag_oe;
	logic rx_space_ready_flag;
	logic rx_enable_n;
	logic rx_start_of_cell;
	logic [BYTE_W-1:0] rx_cell_byte_bus;
	logic [ADDR_W-1:0] rx_slave_select_addr;

	// external pulldown on the shared flag wires
	assign tx_cell_ready_flag = tx_cell_ready_flag_oe & tx_cell_ready_flag_o;
	assign rx_space_ready_flag = rx_space_ready_flag_oe & rx_space_ready_flag_o;

	modport slave (
		input tx_link_clock, tx_enable_n, tx_slave_select_addr,
		input rx_link_clock, rx_enable_n, rx_start_of_cell, rx_cell_byte_bus,
		input rx_slave_select_addr,
		output tx_cell_byte_bus, tx_cell_ready_flag_o, tx_cell_ready_flag_oe,
		output tx_start_of_cell, rx_space_ready_flag_o, rx_space_ready_flag_oe
	);

	modport master (
		output tx_link_clock, tx_enable_n, tx_slave_select_addr,
		output rx_link_clock, rx_enable_n, rx_start_of_cell, rx_cell_byte_bus,
		output rx_slave_select_addr,
		input tx_cell_byte_bus, tx_cell_ready_flag, tx_start_of_cell, rx_space_ready_flag
	);
endinterface

/* File: cell_port_slave.sv */
// cell slave end: byte fifos on the user side, polled cell port on the link side
// assumes link clocks come from the master, much slower than core_clk
module cell_port_slave import cell_port_pkg::*; (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic cell_port_enable_strap,
	input wire logic [ADDR_W-1:0] own_slave_addr,
	input wire logic user_tx_valid,
	output logic user_tx_ready,
	input wire logic [BYTE_W-1:0] user_tx_data,
	output logic user_rx_valid,
	input wire logic user_rx_ready,
	output logic [BYTE_W-1:0] user_rx_data,
	cell_link_if.slave link
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PIN_W = 6 + BYTE_W + 2 * ADDR_W;

	typedef struct packed {
		logic [PIN_W-1:0] pin_s1;
		logic [PIN_W-1:0] pin_s2;
		logic tx_clk_d;
		logic rx_clk_d;
		port_state_t tx_state;
		port_state_t rx_state;
		logic [CNT_W-1:0] tx_cnt;
		logic [CNT_W-1:0] rx_cnt;
		logic tx_sel;
		logic rx_sel;
		logic [BYTE_W-1:0] tx_byte;
		logic tx_soc;
		logic tx_clav;
		logic tx_clav_oe;
		logic rx_clav;
		logic rx_clav_oe;
		logic tx_pop;
		logic rx_push;
		logic [BYTE_W-1:0] rx_byte;
	} slave_state_t;

	slave_state_t st_r;
	slave_state_t st_nxt;
	logic strap_s, tx_clk_s, rx_clk_s, tx_en_n_s, rx_en_n_s, rx_soc_s;
	logic [BYTE_W-1:0] rx_data_s;
	logic [ADDR_W-1:0] rx_addr_s;
	logic [ADDR_W-1:0] tx_addr_s;
	logic tx_match;
	logic rx_match;
	logic tx_head_valid;
	logic [BYTE_W-1:0] tx_head;
	logic [LVL_W-1:0] tx_level;
	logic rx_in_ready;
	logic [LVL_W-1:0] rx_level;

	function automatic logic [ADDR_W-1:0] gate_addr(input logic [ADDR_W-1:0] a,
		input logic en);
		return en ? a : '0;
	endfunction

	assign {strap_s, tx_clk_s, rx_clk_s, tx_en_n_s, rx_en_n_s, rx_soc_s, rx_data_s,
		rx_addr_s, tx_addr_s} = st_r.pin_s2;

	always_comb
	begin
		st_nxt = st_r;
		// every pin, the link clocks included, passes two flops first
		st_nxt.pin_s1 = {cell_port_enable_strap, link.tx_link_clock, link.rx_link_clock,
			link.tx_enable_n, link.rx_enable_n, link.rx_start_of_cell, link.rx_cell_byte_bus,
			link.rx_slave_select_addr, link.tx_slave_select_addr};
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.tx_clk_d = tx_clk_s;
		st_nxt.rx_clk_d = rx_clk_s;
		st_nxt.tx_pop = 1'b0;
		st_nxt.rx_push = 1'b0;
		tx_match = gate_addr(tx_addr_s, strap_s) == own_slave_addr;
		rx_match = gate_addr(rx_addr_s, strap_s) == own_slave_addr;
		if (!strap_s)
		begin
			st_nxt.tx_state = PORT_IDLE;
			st_nxt.rx_state = PORT_IDLE;
			st_nxt.tx_cnt = '0;
			st_nxt.rx_cnt = '0;
			st_nxt.tx_sel = 1'b0;
			st_nxt.rx_sel = 1'b0;
			st_nxt.tx_byte = '0;
			st_nxt.tx_soc = 1'b0;
			st_nxt.tx_clav = 1'b0;
			st_nxt.tx_clav_oe = 1'b0;
			st_nxt.rx_clav = 1'b0;
			st_nxt.rx_clav_oe = 1'b0;
		end
		else
		begin
			// transmit path on its own clock edges
			if (tx_clk_s && !st_r.tx_clk_d)
			begin
				if (tx_en_n_s)
					st_nxt.tx_sel = tx_match;
				unique case (st_r.tx_state)
					PORT_IDLE:
					begin
						if (!tx_en_n_s && st_r.tx_sel && st_r.tx_clav)
						begin
							st_nxt.tx_byte = tx_head;
							st_nxt.tx_soc = 1'b1;
							st_nxt.tx_pop = 1'b1;
							st_nxt.tx_cnt = CNT_W'(1);
							st_nxt.tx_state = PORT_BUSY;
						end
					end
					PORT_BUSY:
					begin
						if (!tx_en_n_s && tx_head_valid)
						begin
							st_nxt.tx_byte = tx_head;
							st_nxt.tx_soc = 1'b0;
							st_nxt.tx_pop = 1'b1;
							if (last_byte(st_r.tx_cnt))
							begin
								st_nxt.tx_cnt = '0;
								st_nxt.tx_state = PORT_IDLE;
							end
							else
								st_nxt.tx_cnt = st_r.tx_cnt + 1'b1;
						end
					end
				endcase
				st_nxt.tx_clav_oe = tx_match;
				// whole cell queued; stays low one edge after a cell while pops settle
				st_nxt.tx_clav = tx_match && st_r.tx_state == PORT_IDLE &&
					st_nxt.tx_state == PORT_IDLE && tx_level >= LVL_W'(CELL_BYTES);
			end
			// receive path timed from master clock
			if (rx_clk_s && !st_r.rx_clk_d)
			begin
				if (rx_en_n_s)
					st_nxt.rx_sel = rx_match;
				if (!rx_en_n_s && st_r.rx_sel && rx_in_ready)
				begin
					unique case (st_r.rx_state)
						PORT_IDLE:
						begin
							if (rx_soc_s && st_r.rx_clav)
							begin
								st_nxt.rx_byte = rx_data_s;
								st_nxt.rx_push = 1'b1;
								st_nxt.rx_cnt = CNT_W'(1);
								st_nxt.rx_state = PORT_BUSY;
							end
						end
						PORT_BUSY:
						begin
							st_nxt.rx_byte = rx_data_s;
							st_nxt.rx_push = 1'b1;
							if (last_byte(st_r.rx_cnt))
							begin
								st_nxt.rx_cnt = '0;
								st_nxt.rx_state = PORT_IDLE;
							end
							else
								st_nxt.rx_cnt = st_r.rx_cnt + 1'b1;
						end
					endcase
				end
				st_nxt.rx_clav_oe = rx_match;
				st_nxt.rx_clav = rx_match && st_r.rx_state == PORT_IDLE &&
					st_nxt.rx_state == PORT_IDLE &&
					(LVL_W'(FIFO_DEPTH) - rx_level) >= LVL_W'(CELL_BYTES);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	cell_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.core_clk(core_clk),
		.rstn(rstn),
		.in_valid(user_tx_valid),
		.in_ready(user_tx_ready),
		.in_data(user_tx_data),
		.out_valid(tx_head_valid),
		.out_ready(st_r.tx_pop),
		.out_data(tx_head),
		.level(tx_level)
	);

	// a full rx fifo holds the space flag low, which stalls the master
	cell_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.core_clk(core_clk),
		.rstn(rstn),
		.in_valid(st_r.rx_push),
		.in_ready(rx_in_ready),
		.in_data(st_r.rx_byte),
		.out_valid(user_rx_valid),
		.out_ready(user_rx_ready),
		.out_data(user_rx_data),
		.level(rx_level)
	);

	assign link.tx_cell_byte_bus = st_r.tx_byte;
	assign link.tx_start_of_cell = st_r.tx_soc;
	assign link.tx_cell_ready_flag_o = st_r.tx_clav;
	assign link.tx_cell_ready_flag_oe = st_r.tx_clav_oe;
	assign link.rx_space_ready_flag_o = st_r.rx_clav;
	assign link.rx_space_ready_flag_oe = st_r.rx_clav_oe;
endmodule

/* File: cell_port_master.sv */
// cell master end: makes both link clocks, polls one slave, moves whole cells
// also holds the byte fifo that the slave end instantiates twice
// assumes the slave answers within half a link period of a rising link edge
module cell_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PTR_W = $clog2(DEPTH);
	localparam int LEV_W = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [LEV_W-1:0] level;
		logic in_ready;
		logic out_valid;
		logic [WIDTH-1:0] head;
	} fifo_state_t;

	fifo_state_t st_r;
	fifo_state_t st_nxt;
	logic push;
	logic pop;

	// flags and head are registered so both sides see flop outputs
	always_comb
	begin
		st_nxt = st_r;
		push = in_valid && st_r.in_ready;
		pop = out_ready && st_r.out_valid;
		if (push)
		begin
			st_nxt.mem[st_r.wr_ptr] = in_data;
			st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
		end
		if (pop)
			st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
		st_nxt.level = st_r.level + LEV_W'(push) - LEV_W'(pop);
		st_nxt.in_ready = st_nxt.level != LEV_W'(DEPTH);
		st_nxt.out_valid = st_nxt.level != '0;
		st_nxt.head = st_nxt.mem[st_nxt.rd_ptr];
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign in_ready = st_r.in_ready;
	assign out_valid = st_r.out_valid;
	assign out_data = st_r.head;
	assign level = st_r.level;
endmodule

module cell_port_master import cell_port_pkg::*; (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] target_slave_addr,
	input wire logic user_tx_valid,
	output logic user_tx_ready,
	input wire logic [BYTE_W-1:0] user_tx_data,
	output logic user_rx_valid,
	output logic user_rx_start,
	output logic [BYTE_W-1:0] user_rx_data,
	cell_link_if.master link
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int IN_W = BYTE_W + 3;

	typedef struct packed {
		logic [IN_W-1:0] pin_s1;
		logic [IN_W-1:0] pin_s2;
		logic [LINK_DIV_W-1:0] div_cnt;
		logic link_clk;
		logic [ADDR_W-1:0] addr;
		move_state_t snd_state;
		logic [CNT_W-1:0] snd_cnt;
		logic rx_en_n;
		logic rx_soc;
		logic [BYTE_W-1:0] rx_byte;
		logic tx_ready;
		move_state_t fch_state;
		logic [CNT_W-1:0] fch_cnt;
		logic tx_en_n;
		logic en_seen;
		logic cap_tx_clav;
		logic cap_rx_clav;
		logic out_valid;
		logic out_start;
		logic [BYTE_W-1:0] out_byte;
	} master_state_t;

	master_state_t st_r;
	master_state_t st_nxt;
	logic [BYTE_W-1:0] tx_data_s;
	logic tx_soc_s, tx_clav_s, rx_clav_s;
	logic wrap, rise, fall, pre_fall;

	function automatic logic last_wait(input logic [CNT_W-1:0] cnt);
		return cnt == CNT_W'(POLL_WAIT_FALLS - 1);
	endfunction

	assign {tx_data_s, tx_soc_s, tx_clav_s, rx_clav_s} = st_r.pin_s2;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.pin_s1 = {link.tx_cell_byte_bus, link.tx_start_of_cell,
			link.tx_cell_ready_flag, link.rx_space_ready_flag};
		st_nxt.pin_s2 = st_r.pin_s1;
		wrap = st_r.div_cnt == LINK_DIV_W'(LINK_HALF_CYCLES - 1);
		rise = wrap && !st_r.link_clk;
		fall = wrap && st_r.link_clk;
		pre_fall = st_r.link_clk && st_r.div_cnt == LINK_DIV_W'(LINK_HALF_CYCLES - 2);
		st_nxt.div_cnt = wrap ? '0 : st_r.div_cnt + 1'b1;
		if (wrap)
			st_nxt.link_clk = !st_r.link_clk;
		st_nxt.out_valid = 1'b0;
		// ready only in the cycle that ends on a falling edge
		st_nxt.tx_ready = pre_fall && st_r.snd_state == MOVE_XFER;
		// sample on rises, drive on falls: half a period of margin either way
		if (rise)
		begin
			st_nxt.cap_tx_clav = tx_clav_s;
			st_nxt.cap_rx_clav = rx_clav_s;
			if (st_r.en_seen)
			begin
				st_nxt.out_valid = 1'b1;
				st_nxt.out_byte = tx_data_s;
				st_nxt.out_start = tx_soc_s;
			end
			st_nxt.en_seen = !st_r.tx_en_n;
		end
		if (fall)
		begin
			st_nxt.addr = target_slave_addr;
			unique case (st_r.snd_state)
				MOVE_POLL:
				begin
					st_nxt.rx_en_n = 1'b1;
					st_nxt.rx_soc = 1'b0;
					st_nxt.snd_cnt = wait_done(st_r.snd_cnt);
					if (last_wait(st_r.snd_cnt))
						st_nxt.snd_state = MOVE_CHECK;
				end
				MOVE_CHECK:
				begin
					if (st_r.cap_rx_clav)
						st_nxt.snd_state = MOVE_XFER;
				end
				MOVE_XFER:
				begin
					if (user_tx_valid && st_r.tx_ready)
					begin
						st_nxt.rx_en_n = 1'b0;
						st_nxt.rx_byte = user_tx_data;
						st_nxt.rx_soc = st_r.snd_cnt == '0;
						if (last_byte(st_r.snd_cnt))
						begin
							st_nxt.snd_cnt = '0;
							st_nxt.snd_state = MOVE_POLL;
						end
						else
							st_nxt.snd_cnt = st_r.snd_cnt + 1'b1;
					end
					else
					begin
						st_nxt.rx_en_n = 1'b1;
						st_nxt.rx_soc = 1'b0;
					end
				end
			endcase
			unique case (st_r.fch_state)
				MOVE_POLL:
				begin
					st_nxt.fch_cnt = wait_done(st_r.fch_cnt);
					if (last_wait(st_r.fch_cnt))
						st_nxt.fch_state = MOVE_CHECK;
				end
				MOVE_CHECK:
				begin
					if (st_r.cap_tx_clav)
					begin
						st_nxt.tx_en_n = 1'b0;
						st_nxt.fch_state = MOVE_XFER;
					end
				end
				MOVE_XFER:
				begin
					// enable held low for exactly one cell of rises
					if (last_byte(st_r.fch_cnt))
					begin
						st_nxt.tx_en_n = 1'b1;
						st_nxt.fch_cnt = '0;
						st_nxt.fch_state = MOVE_POLL;
					end
					else
						st_nxt.fch_cnt = st_r.fch_cnt + 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r <= '0;
			st_r.rx_en_n <= 1'b1;
			st_r.tx_en_n <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign link.tx_link_clock = st_r.link_clk;
	assign link.rx_link_clock = st_r.link_clk;
	assign link.tx_slave_select_addr = st_r.addr;
	assign link.rx_slave_select_addr = st_r.addr;
	assign link.tx_enable_n = st_r.tx_en_n;
	assign link.rx_enable_n = st_r.rx_en_n;
	assign link.rx_start_of_cell = st_r.rx_soc;
	assign link.rx_cell_byte_bus = st_r.rx_byte;
	assign user_tx_ready = st_r.tx_ready;
	assign user_rx_valid = st_r.out_valid;
	assign user_rx_start = st_r.out_start;
	assign user_rx_data = st_r.out_byte;
endmodule

/* File: cell_link_assertions.sv */
// checker for the pins between the cell master end and the cell slave end
// assumes core_clk samples every link pin and the master divides its clock by eight
module cell_link_assertions import cell_port_pkg::*; (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic cell_port_enable_strap,
	input wire logic [ADDR_W-1:0] own_slave_addr,
	input wire logic tx_link_clock,
	input wire logic [BYTE_W-1:0] tx_cell_byte_bus,
	input wire logic tx_cell_ready_flag_oe,
	input wire logic tx_cell_ready_flag,
	input wire logic tx_enable_n,
	input wire logic tx_start_of_cell,
	input wire logic [ADDR_W-1:0] tx_slave_select_addr,
	input wire logic rx_space_ready_flag_oe,
	input wire logic rx_enable_n,
	input wire logic rx_start_of_cell,
	input wire logic [ADDR_W-1:0] rx_slave_select_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] off_cnt_r;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// strap passes two sync flops, so pins are judged only after it stayed low a while
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			off_cnt_r <= '0;
		else if (cell_port_enable_strap)
			off_cnt_r <= '0;
		else if (off_cnt_r != 3'h7)
			off_cnt_r <= off_cnt_r + 3'h1;
	end
	sequence clk_high;
		tx_link_clock [*4];
	endsequence
	sequence clk_low;
		!tx_link_clock [*4];
	endsequence
	a_strap_off_quiet: assert property (off_cnt_r == 3'h7 |-> !tx_cell_ready_flag_oe &&
		!rx_space_ready_flag_oe && tx_cell_byte_bus == '0 && !tx_start_of_cell)
		else $error("port pins active with strap low");
	a_tx_oe_match: assert property ($rose(tx_cell_ready_flag_oe) |->
		$past(tx_slave_select_addr, 4) == own_slave_addr)
		else $error("tx flag driven for a foreign address");
	a_rx_oe_match: assert property ($rose(rx_space_ready_flag_oe) |->
		$past(rx_slave_select_addr, 4) == own_slave_addr)
		else $error("rx flag driven for a foreign address");
	a_soc_after_enable: assert property ($fell(tx_enable_n) && tx_cell_ready_flag |->
		##[1:16] tx_start_of_cell)
		else $error("no start of cell after enable");
	a_soc_one_period: assert property ($rose(tx_start_of_cell) |=>
		tx_start_of_cell [*6] ##[1:3] !tx_start_of_cell)
		else $error("start of cell not one link period");
	a_byte_hold: assert property (tx_start_of_cell && $past(tx_start_of_cell) |->
		$stable(tx_cell_byte_bus))
		else $error("first byte changed inside its link period");
	a_link_clk_shape: assert property ($rose(tx_link_clock) |->
		clk_high ##1 clk_low ##1 tx_link_clock)
		else $error("link clock not four high four low");
	a_rx_soc_enable: assert property (rx_start_of_cell |-> !rx_enable_n)
		else $error("rx start of cell without enable");
	a_rx_addr_steady: assert property ($changed(rx_slave_select_addr) |-> rx_enable_n)
		else $error("rx address moved during a transfer");
endmodule

/* File: tb_top.sv */
// bench: master and slave ends joined by the link, both user sides driven and scored
// assumes one core clock for both ends; the master makes the link clocks
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import cell_port_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic strap = 1'b0;
	logic [ADDR_W-1:0] own_addr, tgt_addr;
	logic s_tx_valid = 1'b0, s_rx_ready = 1'b0, m_tx_valid = 1'b0;
	logic s_tx_ready, s_rx_valid, m_tx_ready, m_rx_valid, m_rx_start;
	logic [BYTE_W-1:0] s_tx_data = '0, m_tx_data = '0, s_rx_data, m_rx_data;
	logic [7:0] q_m[$], q_s[$];
	integer seed = 32'h57cc;
	int num_errors = 0, n_tests = 0, got_m = 0, got_s = 0;
	cell_link_if link();
	cell_port_slave u_cell_port_slave (.core_clk(core_clk), .rstn(rstn),
		.cell_port_enable_strap(strap), .own_slave_addr(own_addr),
		.user_tx_valid(s_tx_valid), .user_tx_ready(s_tx_ready), .user_tx_data(s_tx_data),
		.user_rx_valid(s_rx_valid), .user_rx_ready(s_rx_ready), .user_rx_data(s_rx_data),
		.link(link));
	cell_port_master u_cell_port_master (.core_clk(core_clk), .rstn(rstn),
		.target_slave_addr(tgt_addr), .user_tx_valid(m_tx_valid), .user_tx_ready(m_tx_ready),
		.user_tx_data(m_tx_data), .user_rx_valid(m_rx_valid), .user_rx_start(m_rx_start),
		.user_rx_data(m_rx_data), .link(link));
	cell_link_assertions u_cell_link_assertions (.core_clk(core_clk), .rstn(rstn),
		.cell_port_enable_strap(strap), .own_slave_addr(own_addr),
		.tx_link_clock(link.tx_link_clock), .tx_cell_byte_bus(link.tx_cell_byte_bus),
		.tx_cell_ready_flag_oe(link.tx_cell_ready_flag_oe),
		.tx_cell_ready_flag(link.tx_cell_ready_flag), .tx_enable_n(link.tx_enable_n),
		.tx_start_of_cell(link.tx_start_of_cell),
		.tx_slave_select_addr(link.tx_slave_select_addr),
		.rx_space_ready_flag_oe(link.rx_space_ready_flag_oe), .rx_enable_n(link.rx_enable_n),
		.rx_start_of_cell(link.rx_start_of_cell),
		.rx_slave_select_addr(link.rx_slave_select_addr));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one feeder for both user sides; the idle side keeps valid low
	task automatic feed(input bit mst, input int n);
		int k;
		logic [7:0] d;
		k = 0;
		d = 8'($random(seed));
		while (k < n)
		begin
			m_tx_valid <= mst;
			s_tx_valid <= !mst;
			m_tx_data <= d;
			s_tx_data <= d;
			@(posedge core_clk);
			if ((mst ? m_tx_ready : s_tx_ready) === 1'b1)
			begin
				k++;
				d = 8'($random(seed));
			end
		end
		m_tx_valid <= 1'b0;
		s_tx_valid <= 1'b0;
	endtask
	task automatic wait_cnt(ref int cnt, input int tgt);
		repeat (4000)
			if (cnt < tgt)
				@(posedge core_clk);
		check("byte count", 8'(tgt), 8'(cnt));
	endtask
	initial
	begin
		forever #5 core_clk = ~core_clk;
	end
	// random stalls on the slave's receive fifo
	always @(posedge core_clk)
		s_rx_ready <= 1'($random(seed));
	// reference queues: bytes leave in the order they were accepted
	always @(posedge core_clk)
	begin
		if (s_tx_valid && s_tx_ready === 1'b1)
			q_m.push_back(s_tx_data);
		if (m_tx_valid && m_tx_ready === 1'b1)
			q_s.push_back(m_tx_data);
		if (m_rx_valid === 1'b1)
		begin
			check("fetch start", 8'(got_m % CELL_BYTES == 0), 8'(m_rx_start));
			check("fetched byte", q_m.size() ? q_m.pop_front() : 8'hxx, m_rx_data);
			got_m++;
		end
		if (s_rx_valid === 1'b1 && s_rx_ready)
		begin
			check("received byte", q_s.size() ? q_s.pop_front() : 8'hxx, s_rx_data);
			got_s++;
		end
	end
	initial
	begin
		#200000;
		num_errors++;
		$display("Error watchdog expected done seen hang");
		results();
	end
	initial
	begin
		own_addr = 5'($random(seed)) % 5'd31;
		tgt_addr = own_addr;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge core_clk);
		feed(1'b0, CELL_BYTES);
		repeat (60) @(posedge core_clk);
		check("tied tx oe", 8'h00, 8'(link.tx_cell_ready_flag_oe));
		check("tied rx oe", 8'h00, 8'(link.rx_space_ready_flag_oe));
		check("tied data", 8'h00, link.tx_cell_byte_bus);
		check("strap off fetch", 8'h00, 8'(got_m));
		strap <= 1'b1;
		wait_cnt(got_m, CELL_BYTES);
		tgt_addr <= own_addr ^ 5'h01;
		feed(1'b0, FIFO_DEPTH);
		repeat (60) @(posedge core_clk);
		check("full ready", 8'h00, 8'(s_tx_ready));
		check("foreign oe", 8'h00, 8'(link.tx_cell_ready_flag_oe));
		check("foreign fetch", 8'(CELL_BYTES), 8'(got_m));
		tgt_addr <= own_addr;
		wait_cnt(got_m, 2 * CELL_BYTES);
		repeat (150) @(posedge core_clk);
		check("partial cell", 8'(2 * CELL_BYTES), 8'(got_m));
		feed(1'b0, 8);
		wait_cnt(got_m, 3 * CELL_BYTES);
		feed(1'b1, 2 * CELL_BYTES);
		wait_cnt(got_s, 2 * CELL_BYTES);
		repeat (100) @(posedge core_clk);
		check("rx residue", 8'h00, 8'(q_s.size()));
		check("tx residue", 8'h00, 8'(q_m.size()));
		results();
	end
endmodule
